// ### src/pccs_config_regs.sv
// Function
// - Offset 00h returns a fixed 16-bit maker code; writes ignored.
// - Offset 02h returns a fixed 16-bit part code; writes ignored.
// - Command bits 15:10 always read zero.
// - Command bit 9 back-to-back enable is read-only zero.
// - Command bit 8 enables driving system error on address parity errors.
// - Command bit 7 stepping control is hardwired zero.
// - Command bit 6 gates the parity error output on data parity errors.
// - Command bits 5, 3 and 0 read zero.
// - Command bit 4 allows write-and-invalidate, else plain memory write.
// - Command bit 2 gates the initiator bus request.
// - Command bit 1 gates claiming memory cycles; host sets it first.
// - Status bit 15 sets on any detected parity error.
// - Status bit 14 sets whenever system error is asserted.
// - Status bit 13 sets on master-abort of own non-special transaction.
// - Status bit 12 sets when own transaction receives target-abort.
// - Status bit 11 sets when device as target signals target-abort.
// - Status bits 10:9 report medium select timing, code 01.
// - Status bit 8 sets per master data parity rules; its clear is gated by byte enable 2, the others by byte enable 3.
// - Status bit 7 back-to-back capability is read-only, conflict resolved.
// - Status bit 5 reads zero: no high-speed operation.
// - Status bit 4 read-only: capability list flag, set by CAP_LIST.
`timescale 1ns/1ps
`default_nettype none

module pccs_config_regs
    import pccs_pkg::*;
#(
    parameter logic [15:0] MAKER_ID   = 16'h1234,   // Arbitrary value.
    parameter logic [15:0] PART_ID    = 16'habcd,   // Arbitrary value.
    parameter logic        B2B_CAP    = 1'b1,
    parameter logic        CAP_LIST   = 1'b1
) (
    input  wire logic                   mclk,                      // 25 MHz clock.
    input  wire logic                   srst,                      // Sync reset.
    input  wire pccs_pkg::pccs_cfg_req_t cfg_req,                  // Config access.
    output logic                        cfg_ack,                   // Access done.
    output logic [31:0]                 cfg_rdata,                 // Read data.
    input  wire pccs_pkg::pccs_events_t bus_events,                // Bus events.
    input  wire logic                   master_req_in,             // Engine wants bus.
    output logic                        master_req_out,            // Gated request.
    input  wire logic                   master_want_mwi,           // Engine wants MWI.
    output logic                        master_use_mwi,            // MWI allowed.
    input  wire logic                   mem_addr_hit,              // Memory decode hit.
    output logic                        mem_claim,                 // Claim the cycle.
    output logic                        initiator_enable,          // Command bit 2.
    output logic                        memory_decode_enable,      // Command bit 1.
    output logic                        write_invalidate_enable,   // Command bit 4.
    output logic                        parity_response_enable,    // Command bit 6.
    output logic                        system_error_drive_enable, // Command bit 8.
    output logic                        system_error_out_n,        // Error pin value.
    output logic                        system_error_oe,           // Error pin enable.
    output logic                        parity_error_out_n,        // Parity pin value.
    output logic                        parity_error_oe            // Parity pin enable.
);
    import pccs_pkg::*;

    logic [15:0]           command;
    logic [15:0]           status;
    logic [FLAG_COUNT-1:0] flags;
    logic [FLAG_COUNT-1:0] flag_set;
    logic [FLAG_COUNT-1:0] flag_clr;
    logic                  wr_cmd_sts;
    logic                  next_serr;
    logic                  next_perr;
    logic                  perr_hold;

    // ------------------------------------------------------------------
    // Byte-lane merge
    // ------------------------------------------------------------------
    function automatic logic [15:0] lane_bits(input logic [1:0] be);
        lane_bits = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    assign wr_cmd_sts = cfg_req.valid && cfg_req.write && (cfg_req.dword == DW_CMD_STS);

    // ------------------------------------------------------------------
    // Command word
    // ------------------------------------------------------------------
    // writable mask
    // Only the enable bits hold storage; every other bit is a constant zero.
    always_ff @(posedge mclk) begin
        if (srst) begin
            command <= CMD_RESET;
        end else if (wr_cmd_sts) begin
            command <= (command & ~(CMD_WRITE_MASK & lane_bits(cfg_req.byte_en[1:0])))
                     | (cfg_req.wdata[15:0] & CMD_WRITE_MASK & lane_bits(cfg_req.byte_en[1:0]));
        end
    end

    assign system_error_drive_enable = command[CMD_SERR_EN];
    assign parity_response_enable    = command[CMD_PERR_EN];
    assign write_invalidate_enable   = command[CMD_MWI_EN];
    assign initiator_enable          = command[CMD_MASTER_EN];
    assign memory_decode_enable      = command[CMD_MEM_EN];

    // ------------------------------------------------------------------
    // Gating of bus behaviour
    // ------------------------------------------------------------------
    // initiator gate
    assign master_req_out = master_req_in && initiator_enable;
    assign master_use_mwi = master_want_mwi && write_invalidate_enable;
    assign mem_claim      = mem_addr_hit && memory_decode_enable;

    // ------------------------------------------------------------------
    // Error pins
    // ------------------------------------------------------------------
    // system error drive
    assign next_serr = bus_events.addr_parity_err && system_error_drive_enable;
    assign next_perr = bus_events.data_parity_err && parity_response_enable;

    // System error is open drain: pull low for one cycle, otherwise release.
    always_ff @(posedge mclk) begin
        if (srst) begin
            system_error_oe <= 1'b0;
        end else begin
            system_error_oe <= next_serr;
        end
    end
    assign system_error_out_n = 1'b0;

    // The parity pin is driven low one cycle, then high one more cycle before
    // release, so the line is not left floating low.
    always_ff @(posedge mclk) begin
        if (srst) begin
            parity_error_out_n <= 1'b1;
            parity_error_oe    <= 1'b0;
            perr_hold          <= 1'b0;
        end else begin
            parity_error_out_n <= !next_perr;
            perr_hold          <= next_perr;
            parity_error_oe    <= next_perr || perr_hold;
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    always_comb begin
        flag_set = '0;
        flag_set[PCCS_F_DET_PAR]  = bus_events.addr_parity_err || bus_events.data_parity_err;
        flag_set[PCCS_F_SIG_SERR] = next_serr;
        flag_set[PCCS_F_RCV_MABT] = bus_events.master_abort && !bus_events.master_abort_special;
        flag_set[PCCS_F_RCV_TABT] = bus_events.target_abort_rcvd;
        flag_set[PCCS_F_SIG_TABT] = bus_events.target_abort_sent;
        flag_set[PCCS_F_MDPE]     = bus_events.master_parity_err && parity_response_enable;
    end

    always_comb begin
        flag_clr = '0;
        if (wr_cmd_sts && cfg_req.byte_en[3]) begin
            flag_clr[PCCS_F_DET_PAR]  = cfg_req.wdata[STS_WORD_LSB + STS_DET_PAR];
            flag_clr[PCCS_F_SIG_SERR] = cfg_req.wdata[STS_WORD_LSB + STS_SIG_SERR];
            flag_clr[PCCS_F_RCV_MABT] = cfg_req.wdata[STS_WORD_LSB + STS_RCV_MABT];
            flag_clr[PCCS_F_RCV_TABT] = cfg_req.wdata[STS_WORD_LSB + STS_RCV_TABT];
            flag_clr[PCCS_F_SIG_TABT] = cfg_req.wdata[STS_WORD_LSB + STS_SIG_TABT];
        end
        if (wr_cmd_sts && cfg_req.byte_en[2]) begin
            flag_clr[PCCS_F_MDPE] = cfg_req.wdata[STS_WORD_LSB + STS_MDPE];
        end
    end

    pccs_sticky_flags #(
        .WIDTH (FLAG_COUNT)
    ) u_flags (
        .mclk  (mclk),
        .srst  (srst),
        .set   (flag_set),
        .clear (flag_clr),
        .flags (flags)
    );

    // fixed status bits
    // Back-to-back capability follows the documented reset word, not the prose.
    always_comb begin
        status                  = '0;
        status[STS_DET_PAR]     = flags[PCCS_F_DET_PAR];
        status[STS_SIG_SERR]    = flags[PCCS_F_SIG_SERR];
        status[STS_RCV_MABT]    = flags[PCCS_F_RCV_MABT];
        status[STS_RCV_TABT]    = flags[PCCS_F_RCV_TABT];
        status[STS_SIG_TABT]    = flags[PCCS_F_SIG_TABT];
        status[STS_DEVSEL_LSB +: 2] = STS_DEVSEL_MEDIUM;
        status[STS_MDPE]        = flags[PCCS_F_MDPE];
        status[STS_B2B_CAP]     = B2B_CAP;
        status[STS_HIGH_SPD]    = 1'b0;
        status[STS_CAP_LIST]    = CAP_LIST;
    end

    // ------------------------------------------------------------------
    // Config read path
    // ------------------------------------------------------------------
    // identification read
    // Unmapped dwords read as zero and swallow writes, so probing is harmless.
    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= '0;
        end else begin
            cfg_ack <= cfg_req.valid;
            if (cfg_req.valid && !cfg_req.write) begin
                case (cfg_req.dword)
                    DW_IDENT: begin
                        cfg_rdata <= {PART_ID, MAKER_ID};
                    end
                    DW_CMD_STS: begin
                        cfg_rdata <= {status, command};
                    end
                    default: begin
                        cfg_rdata <= '0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    cmd_reserved_zero_a: assert property (@(posedge mclk) disable iff (srst)
        (command & ~CMD_WRITE_MASK) == 16'h0000)
        else $error("Command read-only bits not zero.");

    status_fixed_a: assert property (@(posedge mclk) disable iff (srst)
        status[STS_DEVSEL_LSB +: 2] == STS_DEVSEL_MEDIUM && !status[STS_HIGH_SPD]
        && status[3:0] == 4'h0)
        else $error("Status fixed fields wrong.");

    ident_read_a: assert property (@(posedge mclk) disable iff (srst)
        cfg_req.valid && !cfg_req.write && cfg_req.dword == DW_IDENT
        |=> cfg_ack && cfg_rdata == {PART_ID, MAKER_ID})
        else $error("Identification read wrong.");

    parity_flag_set_a: assert property (@(posedge mclk) disable iff (srst)
        bus_events.data_parity_err || bus_events.addr_parity_err
        |=> status[STS_DET_PAR])
        else $error("Detected parity flag not set.");

    serr_flag_a: assert property (@(posedge mclk) disable iff (srst)
        system_error_oe |-> status[STS_SIG_SERR] && $past(command[CMD_SERR_EN]))
        else $error("System error flag or enable mismatch.");

    perr_gate_a: assert property (@(posedge mclk) disable iff (srst)
        $rose(parity_error_oe) |-> !parity_error_out_n && $past(command[CMD_PERR_EN])
        ##1 parity_error_oe && (parity_error_out_n == !$past(next_perr)))
        else $error("Parity pin sequence wrong.");

    mem_claim_gate_a: assert property (@(posedge mclk) disable iff (srst)
        mem_claim |-> command[CMD_MEM_EN] && mem_addr_hit)
        else $error("Memory claimed while disabled.");

    master_gate_a: assert property (@(posedge mclk) disable iff (srst)
        master_req_out |-> command[CMD_MASTER_EN] && master_req_in)
        else $error("Initiator request while disabled.");

    mwi_gate_a: assert property (@(posedge mclk) disable iff (srst)
        master_use_mwi |-> command[CMD_MWI_EN])
        else $error("Write-invalidate used while disabled.");

    abort_flag_a: assert property (@(posedge mclk) disable iff (srst)
        bus_events.master_abort && bus_events.master_abort_special
        && !status[STS_RCV_MABT] |=> !status[STS_RCV_MABT])
        else $error("Special-cycle abort set the flag.");

    master_abort_flag_a: assert property (@(posedge mclk) disable iff (srst)
        bus_events.master_abort && !bus_events.master_abort_special |=> status[STS_RCV_MABT])
        else $error("Master-abort flag not set.");

    rcvd_abort_set_a: assert property (@(posedge mclk) disable iff (srst)
        bus_events.target_abort_rcvd |=> status[STS_RCV_TABT])
        else $error("Received target-abort flag not set.");

    sent_abort_set_a: assert property (@(posedge mclk) disable iff (srst)
        bus_events.target_abort_sent |=> status[STS_SIG_TABT])
        else $error("Signalled target-abort flag not set.");

    serr_pin_drive_a: assert property (@(posedge mclk) disable iff (srst)
        bus_events.addr_parity_err && system_error_drive_enable |=> system_error_oe)
        else $error("System error pin not driven.");

    mdpe_flag_gate_a: assert property (@(posedge mclk) disable iff (srst)
        $rose(status[STS_MDPE]) |-> $past(bus_events.master_parity_err && parity_response_enable))
        else $error("Master data parity flag set without cause.");

    w1c_clear_a: assert property (@(posedge mclk) disable iff (srst)
        wr_cmd_sts && cfg_req.byte_en[3] && cfg_req.wdata[16 + STS_SIG_TABT]
        && !bus_events.target_abort_sent |=> !status[STS_SIG_TABT])
        else $error("Signalled target-abort flag not cleared.");

endmodule

`default_nettype wire

// ### src/pccs_pkg.sv
`default_nettype none

package pccs_pkg;

    // ------------------------------------------------------------------
    // Configuration space layout
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_MAKER_ID  = 8'h00;
    localparam logic [7:0] OFS_PART_ID   = 8'h02;
    localparam logic [7:0] OFS_COMMAND   = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h06;
    localparam logic [5:0] DW_IDENT      = OFS_MAKER_ID[7:2];
    localparam logic [5:0] DW_CMD_STS    = OFS_COMMAND[7:2];
    // The status word rides in the upper half of the command/status dword.
    localparam int STS_WORD_LSB  = 16;

    // ------------------------------------------------------------------
    // Command word fields
    // ------------------------------------------------------------------
    localparam int CMD_SERR_EN   = 8;
    localparam int CMD_PERR_EN   = 6;
    localparam int CMD_MWI_EN    = 4;
    localparam int CMD_MASTER_EN = 2;
    localparam int CMD_MEM_EN    = 1;
    localparam logic [15:0] CMD_WRITE_MASK = 16'h0156;
    localparam logic [15:0] CMD_RESET      = 16'h0000;

    // ------------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------------
    localparam int STS_DET_PAR   = 15;
    localparam int STS_SIG_SERR  = 14;
    localparam int STS_RCV_MABT  = 13;
    localparam int STS_RCV_TABT  = 12;
    localparam int STS_SIG_TABT  = 11;
    localparam int STS_MDPE      = 8;
    localparam int STS_B2B_CAP   = 7;
    localparam int STS_HIGH_SPD  = 5;
    localparam int STS_DEVSEL_LSB = 9;
    localparam int STS_CAP_LIST  = 4;
    localparam logic [1:0]  STS_DEVSEL_MEDIUM = 2'h1;
    localparam logic [15:0] STS_RESET         = 16'h0290;
    localparam int FLAG_COUNT = 6;

    // Config access request, one cycle wide.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [5:0]  dword;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } pccs_cfg_req_t;

    // Bus events reported by the bus engine, each a one-cycle pulse.
    typedef struct packed {
        logic addr_parity_err;
        logic data_parity_err;
        logic master_parity_err;
        logic master_abort;
        logic master_abort_special;
        logic target_abort_rcvd;
        logic target_abort_sent;
    } pccs_events_t;

    // Sticky flag order inside the flag vector.
    typedef enum int {
        PCCS_F_MDPE, PCCS_F_SIG_TABT, PCCS_F_RCV_TABT,
        PCCS_F_RCV_MABT, PCCS_F_SIG_SERR, PCCS_F_DET_PAR
    } pccs_flag_t;

endpackage

`default_nettype wire

// ### src/pccs_sticky_flags.sv
`timescale 1ns/1ps
`default_nettype none

module pccs_sticky_flags #(
    parameter int WIDTH = 6
) (
    input  wire logic             mclk,    // Clock.
    input  wire logic             srst,    // Synchronous reset.
    input  wire logic [WIDTH-1:0] set,     // Hardware set pulses.
    input  wire logic [WIDTH-1:0] clear,   // Write-one-to-clear pulses.
    output logic      [WIDTH-1:0] flags    // Sticky flags.
);

    // ------------------------------------------------------------------
    // Flag storage
    // ------------------------------------------------------------------
    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge mclk) begin
        if (srst) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clear) | set;
        end
    end

endmodule

`default_nettype wire

// ### verif/pccs_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pccs_host_model
    import pccs_pkg::*;
(
    input  wire logic                    mclk,      // Clock.
    output var  pccs_pkg::pccs_cfg_req_t cfg_req,   // Request to the device.
    input  wire logic                    cfg_ack,   // Completion pulse.
    input  wire logic [31:0]             cfg_rdata  // Read data.
);
    import pccs_pkg::*;

    initial cfg_req = '0;

    // ------------------------------------------------------------------
    // Configuration cycles
    // ------------------------------------------------------------------
    // host programs and clears
    // Fields are scrambled once the request is gone, so the device
    // cannot lean on stale values left over from the last request.
    // Valid is a one-cycle pulse; holding it would issue a second access.
    task automatic cfg_access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                              input logic [31:0] wd, output logic [31:0] rd, output bit ok);
        ok = 1'b0;
        rd = '0;
        @(posedge mclk);
        cfg_req <= '{valid: 1'b1, write: wr, dword: dw, byte_en: be, wdata: wd};
        @(posedge mclk);
        cfg_req <= '{valid: 1'b0, write: ~wr, dword: ~dw, byte_en: ~be, wdata: ~wd};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge mclk);
            if (cfg_ack === 1'b1) begin
                ok = 1'b1;
                rd = cfg_rdata;
            end
        end
    endtask
endmodule

`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import pccs_pkg::*;

    typedef struct {
        logic [15:0] cmd;
        logic [6:0]  ev;
        logic [15:0] sts;
        logic [2:0]  serr;
        logic [2:0]  perr;
        logic [2:0]  poe;
    } pccs_row_t;

    // Command written, event pulse, status expected, pin levels over three cycles.
    pccs_row_t rows [10] = '{
        '{16'h0000, 7'h40, 16'h8290, 3'h7, 3'h7, 3'h0},
        '{16'h0100, 7'h40, 16'hc290, 3'h6, 3'h7, 3'h0},
        '{16'h0000, 7'h20, 16'h8290, 3'h7, 3'h7, 3'h0},
        '{16'h0040, 7'h20, 16'h8290, 3'h7, 3'h6, 3'h3},
        '{16'h0000, 7'h30, 16'h8290, 3'h7, 3'h7, 3'h0},
        '{16'h0040, 7'h30, 16'h8390, 3'h7, 3'h6, 3'h3},
        '{16'h0004, 7'h08, 16'h2290, 3'h7, 3'h7, 3'h0},
        '{16'h0010, 7'h0c, 16'h0290, 3'h7, 3'h7, 3'h0},
        '{16'h0002, 7'h02, 16'h1290, 3'h7, 3'h7, 3'h0},
        '{16'hffff, 7'h01, 16'h0a90, 3'h7, 3'h7, 3'h0}
    };

    logic          mclk;
    logic          srst;
    pccs_cfg_req_t cfg_req;
    pccs_events_t  bus_events;
    logic          master_req_in, master_want_mwi, mem_addr_hit, cfg_ack;
    logic [31:0]   cfg_rdata, rd;
    logic          master_req_out, master_use_mwi, mem_claim, initiator_enable;
    logic          memory_decode_enable, write_invalidate_enable, parity_response_enable;
    logic          system_error_drive_enable, system_error_out_n, system_error_oe;
    logic          parity_error_out_n, parity_error_oe, serr_wire, perr_wire;
    int            miscompares = 0;
    int            cmp_count = 0;

    // Both error lines have a pull-up on the bus; only the system error line is open drain.
    assign serr_wire = system_error_oe ? system_error_out_n : 1'b1;
    assign perr_wire = parity_error_oe ? parity_error_out_n : 1'b1;

    pccs_config_regs pccs_config_regs_inst (
        .mclk(mclk), .srst(srst), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .bus_events(bus_events), .master_req_in(master_req_in),
        .master_req_out(master_req_out), .master_want_mwi(master_want_mwi),
        .master_use_mwi(master_use_mwi), .mem_addr_hit(mem_addr_hit), .mem_claim(mem_claim),
        .initiator_enable(initiator_enable), .memory_decode_enable(memory_decode_enable),
        .write_invalidate_enable(write_invalidate_enable),
        .parity_response_enable(parity_response_enable),
        .system_error_drive_enable(system_error_drive_enable),
        .system_error_out_n(system_error_out_n), .system_error_oe(system_error_oe),
        .parity_error_out_n(parity_error_out_n), .parity_error_oe(parity_error_oe)
    );

    pccs_host_model pccs_host_model_inst (
        .mclk(mclk), .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic end_of_test();
        if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cfg(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] data);
        bit ok;
        pccs_host_model_inst.cfg_access(wr, dw, be, wd, data, ok);
        if (!ok) begin
            miscompares++;
            $display("[FAIL] cfg_ack expected 1 seen 0");
            end_of_test();
        end
    endtask

    task automatic pulse(input logic [6:0] ev);
        @(posedge mclk);
        bus_events <= pccs_events_t'(ev);
        @(posedge mclk);
        bus_events <= '0;
    endtask

    initial begin
        srst = 1'b1;
        bus_events = '0;
        master_req_in = 1'b0;
        master_want_mwi = 1'b0;
        mem_addr_hit = 1'b0;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        cfg(1'b0, 6'h01, 4'hf, 32'h0, rd);
        check("reset_cmd_status", 32'h0290_0000, rd);
        cfg(1'b1, 6'h00, 4'hf, 32'hffff_ffff, rd);
        cfg(1'b0, 6'h00, 4'hf, 32'h0, rd);
        check("ident", 32'habcd_1234, rd);
        cfg(1'b0, 6'h05, 4'hf, 32'h0, rd);
        check("unmapped", 32'h0, rd);

        for (int i = 0; i < 10; i++) begin
            logic [15:0] c;
            c = rows[i].cmd & 16'h0156;
            cfg(1'b1, 6'h01, 4'h3, {16'h0000, rows[i].cmd}, rd);
            @(posedge mclk);
            master_req_in <= i[0];
            master_want_mwi <= i[0];
            mem_addr_hit <= i[0];
            pulse(rows[i].ev);
            for (int k = 0; k < 3; k++) begin
                @(negedge mclk);
                check("serr_wire", rows[i].serr[k], serr_wire);
                check("perr_wire", rows[i].perr[k], perr_wire);
                check("perr_oe", rows[i].poe[k], parity_error_oe);
            end
            check("gating", {i[0] & c[2], i[0] & c[4], i[0] & c[1]},
                  {master_req_out, master_use_mwi, mem_claim});
            check("enables", {c[8], c[6], c[4], c[2], c[1]},
                  {system_error_drive_enable, parity_response_enable, write_invalidate_enable,
                   initiator_enable, memory_decode_enable});
            cfg(1'b0, 6'h01, 4'hf, 32'h0, rd);
            check("cmd_status", {rows[i].sts, c}, rd);
            cfg(1'b1, 6'h01, 4'hc, 32'hffff_0000, rd);
        end

        pulse(7'h09);
        cfg(1'b1, 6'h01, 4'h8, 32'h2000_0000, rd);
        cfg(1'b0, 6'h01, 4'hf, 32'h0, rd);
        check("one_cleared", 32'h0a90_0156, rd);
        cfg(1'b1, 6'h01, 4'hf, 32'h0000_0156, rd);
        cfg(1'b0, 6'h01, 4'hf, 32'h0, rd);
        check("zero_kept", 32'h0a90_0156, rd);
        cfg(1'b1, 6'h01, 4'hf, 32'h0800_0156, rd);
        cfg(1'b0, 6'h01, 4'hf, 32'h0, rd);
        check("all_cleared", 32'h0290_0156, rd);

        // A reset in mid-run must drop both the flags and the command word.
        pulse(7'h08);
        @(posedge mclk);
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        cfg(1'b0, 6'h01, 4'hf, 32'h0, rd);
        check("rerun_reset", 32'h0290_0000, rd);
        end_of_test();
    end
endmodule

`default_nettype wire
